//--- core/coef_memory.sv
`timescale 1ns/1ps
`default_nettype none
module coef_memory (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Load port
  input wire logic load,
  input wire logic [mcfir_pkg::COEF_W-1:0] load_data,
  // Read port
  input wire logic read_en,
  input wire logic [mcfir_pkg::SEL_W-1:0] read_addr,
  output logic [mcfir_pkg::COEF_W-1:0] coef
);
  logic [mcfir_pkg::COEF_W-1:0] mem [mcfir_pkg::CHANNELS];
  logic [mcfir_pkg::SEL_W-1:0] wr_addr;

  // Six-deep load sequence, one entry per clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_addr <= mcfir_pkg::SEL_RESET;
    end else if (load) begin
      wr_addr <= (wr_addr == mcfir_pkg::SEL_LAST) ? mcfir_pkg::SEL_RESET : wr_addr + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < mcfir_pkg::CHANNELS; i++) begin
        mem[i] <= '0;
      end
    end else if (load) begin
      mem[wr_addr] <= load_data; // (RULE9)
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coef <= '0;
    end else if (read_en) begin
      coef <= mem[read_addr];
    end
  end
endmodule // coef_memory
`default_nettype wire

//--- core/multichannel_fir_filter.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (RULE1) Six channels, eight taps, one shared time-multiplexed datapath.
// (RULE2) Samples and coefficients are 8 bits; mux replicated per bit.
// (RULE3) Single clock at six times the channel sample rate.
// (RULE4) Counter picks channels in order, one per clock; six ticks per period.
// (RULE5) Interleaving shift register is channels plus one deep.
// (RULE6) Each tap delays interleaved samples by seven clocks.
// (RULE7) Tap products cascade into next tap's adder along the chain.
// (RULE8) Shared mode stores one set; per-channel mode six sets per tap.
// (RULE9) Coefficient memories are 8 bits wide, six deep, loadable.
// (RULE10) Load signal held high six consecutive clocks to fill memories.
// (RULE11) Tap reads staggered by enables, delayed by shift register length.
// (RULE12) Output enabled after (channels+1)*taps plus three pipeline stages.
// (RULE13) Mux is registered, one gate level, select fanout split per bit.
// (RULE14) Output valid low until latency expires, then stays high.
module multichannel_fir_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Channel sample inputs
  input wire logic [mcfir_pkg::DATA_W-1:0] ch_sample [mcfir_pkg::CHANNELS],
  // Coefficient control
  input wire logic per_channel_coefs,
  input wire logic coef_load_start,
  input wire logic [mcfir_pkg::COEF_W-1:0] coef_load_data [mcfir_pkg::TAPS],
  // Filtered interleaved output
  output logic out_valid,
  input wire logic out_ready,
  output logic [mcfir_pkg::ACC_W-1:0] out_data,
  output logic [mcfir_pkg::SEL_W-1:0] out_channel,
  output logic overflow,
  output logic coef_loading
);
  localparam int N = mcfir_pkg::TAPS;
  localparam int W = mcfir_pkg::DATA_W;
  localparam int AW = mcfir_pkg::ACC_W;
  localparam int SW = mcfir_pkg::SEL_W;

  function automatic logic [SW-1:0] next_sel(input logic [SW-1:0] s);
    next_sel = (s == mcfir_pkg::SEL_LAST) ? mcfir_pkg::SEL_RESET : s + 1'b1;
  endfunction

  mcfir_pkg::ctl_state_e state;
  logic [SW-1:0] sel;
  logic [SW-1:0] sel_bit [W];
  logic [W-1:0] mux_q;
  logic [SW-1:0] mux_ch;
  logic [W-1:0] ilv [mcfir_pkg::INTERLEAVE_DEPTH];
  logic [SW-1:0] ilv_ch [mcfir_pkg::INTERLEAVE_DEPTH];
  logic [W-1:0] tap_in [N+1];
  logic [W-1:0] tap_dly [N][mcfir_pkg::TAP_DELAY];
  logic [SW-1:0] ch_dly [N+1];
  logic [SW-1:0] ch_pipe [N*mcfir_pkg::TAP_DELAY+mcfir_pkg::SLICE_PIPE+4];
  logic [N-1:0] tap_en;
  logic [SW-1:0] load_cnt;
  logic [mcfir_pkg::LAT_W-1:0] lat_cnt;
  logic [mcfir_pkg::COEF_W-1:0] coef_q [N];
  logic [mcfir_pkg::COEF_W-1:0] shared_q [N];
  logic signed [AW-1:0] casc [N+1];
  logic signed [AW-1:0] mult_q [N];
  logic signed [AW-1:0] prod_q [N];
  logic signed [AW-1:0] sum_q;
  logic signed [AW-1:0] res_q;
  logic filter_ready;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [AW+SW-1:0] fifo_out;
  logic [SW-1:0] result_ch;

  // Channel select counter, one channel per clock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sel <= mcfir_pkg::SEL_RESET;
    end else begin
      sel <= next_sel(sel); // (RULE4) (RULE3)
    end
  end

  // Per-bit select copies cut the select fanout
  genvar b;
  generate
    for (b = 0; b < W; b++) begin : g_mux
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sel_bit[b] <= mcfir_pkg::SEL_RESET;
        end else begin
          sel_bit[b] <= next_sel(sel); // (RULE13)
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mux_q[b] <= 1'b0;
        end else begin
          mux_q[b] <= ch_sample[sel_bit[b]][b]; // (RULE2) (RULE13)
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mux_ch <= '0;
    end else begin
      mux_ch <= sel_bit[0];
    end
  end

  // Interleaving shift register, channels plus one deep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < mcfir_pkg::INTERLEAVE_DEPTH; i++) begin
        ilv[i] <= '0;
      end
    end else begin
      ilv[0] <= mux_q; // (RULE5)
      for (int i = 1; i < mcfir_pkg::INTERLEAVE_DEPTH; i++) begin
        ilv[i] <= ilv[i-1];
      end
    end
  end

  // Channel tags travel beside the samples
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < mcfir_pkg::INTERLEAVE_DEPTH; i++) begin
        ilv_ch[i] <= '0;
      end
    end else begin
      ilv_ch[0] <= mux_ch;
      for (int i = 1; i < mcfir_pkg::INTERLEAVE_DEPTH; i++) begin
        ilv_ch[i] <= ilv_ch[i-1];
      end
    end
  end

  assign tap_in[0] = ilv[mcfir_pkg::INTERLEAVE_DEPTH-1];
  assign ch_dly[0] = ilv_ch[mcfir_pkg::INTERLEAVE_DEPTH-1];
  assign casc[0] = '0;

  // Control: load sequence, staggered tap enables, latency count
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= mcfir_pkg::ctl_idle;
      load_cnt <= '0;
    end else begin
      case (state)
        mcfir_pkg::ctl_idle: begin
          state <= coef_load_start ? mcfir_pkg::ctl_load : mcfir_pkg::ctl_fill;
          load_cnt <= '0;
        end
        mcfir_pkg::ctl_load: begin
          load_cnt <= load_cnt + 1'b1;
          if (load_cnt == SW'(mcfir_pkg::LOAD_CYCLES - 1)) begin
            state <= mcfir_pkg::ctl_fill; // (RULE10)
          end
        end
        mcfir_pkg::ctl_fill: begin
          if (coef_load_start) begin
            state <= mcfir_pkg::ctl_load;
            load_cnt <= '0;
          end else if (filter_ready) begin
            state <= mcfir_pkg::ctl_run;
          end
        end
        mcfir_pkg::ctl_run: begin
          if (coef_load_start) begin
            state <= mcfir_pkg::ctl_load;
            load_cnt <= '0;
          end
        end
        default: state <= mcfir_pkg::ctl_idle;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coef_loading <= 1'b0;
    end else begin
      coef_loading <= (state == mcfir_pkg::ctl_load); // (RULE10)
    end
  end

  // Latency counter restarts with every load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lat_cnt <= '0;
    end else if (state == mcfir_pkg::ctl_load) begin
      lat_cnt <= '0;
    end else if (!filter_ready) begin
      lat_cnt <= lat_cnt + 1'b1;
    end
  end

  // Output enable once the latency has run out
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      filter_ready <= 1'b0;
    end else if (state == mcfir_pkg::ctl_load) begin
      filter_ready <= 1'b0;
    end else if (!filter_ready) begin
      filter_ready <= (lat_cnt == mcfir_pkg::LAT_W'(mcfir_pkg::LATENCY - 1)); // (RULE12) (RULE14)
    end
  end

  // Tap enables ripple one shift register length apart
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tap_en <= '0;
    end else if (state == mcfir_pkg::ctl_load) begin
      tap_en <= '0;
    end else begin
      for (int t = 0; t < N; t++) begin
        tap_en[t] <= (lat_cnt >= mcfir_pkg::LAT_W'(t * mcfir_pkg::TAP_DELAY)) || filter_ready; // (RULE11)
      end
    end
  end

  // Tap chain with cascaded products
  genvar t;
  generate
    for (t = 0; t < N; t++) begin : g_tap
      logic [mcfir_pkg::COEF_W-1:0] sel_coef;
      coef_memory u_coef (
        .clk(clk),
        .rst(rst),
        .load(coef_loading),
        .load_data(coef_load_data[t]),
        .read_en(tap_en[t]),
        .read_addr(ch_dly[t]),
        .coef(coef_q[t])
      );
      // Shared set: the word loaded while this tap's channel tag is zero serves every channel
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          shared_q[t] <= '0;
        end else if (coef_loading && ch_dly[t] == mcfir_pkg::SEL_RESET) begin
          shared_q[t] <= coef_load_data[t];
        end
      end
      always_comb begin
        if (per_channel_coefs) begin
          sel_coef = coef_q[t]; // (RULE8)
        end else begin
          sel_coef = shared_q[t];
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          for (int i = 0; i < mcfir_pkg::TAP_DELAY; i++) begin
            tap_dly[t][i] <= '0;
          end
        end else begin
          tap_dly[t][0] <= tap_in[t]; // (RULE6)
          for (int i = 1; i < mcfir_pkg::TAP_DELAY; i++) begin
            tap_dly[t][i] <= tap_dly[t][i-1];
          end
        end
      end
      // Full-width product register, widened before the multiply
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mult_q[t] <= '0;
        end else begin
          mult_q[t] <= AW'($signed(tap_in[t])) * AW'($signed(sel_coef)); // (RULE1)
        end
      end
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          prod_q[t] <= '0;
        end else if (tap_en[t]) begin
          prod_q[t] <= casc[t] + mult_q[t]; // (RULE7)
        end
      end
      assign casc[t+1] = prod_q[t];
      assign tap_in[t+1] = tap_dly[t][mcfir_pkg::TAP_DELAY-1];
      assign ch_dly[t+1] = ch_dly[t];
    end
  endgenerate

  // Output pipeline stages and channel tag alignment
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sum_q <= '0;
      res_q <= '0;
    end else begin
      sum_q <= casc[N];
      res_q <= sum_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      result_ch <= '0;
    end else begin
      result_ch <= ch_dly[N];
    end
  end

  // Overflow flag sticks when the FIFO refuses a result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overflow <= 1'b0;
    end else if (filter_ready && !fifo_in_ready) begin
      overflow <= 1'b1;
    end
  end

  stream_fifo #(
    .WIDTH(AW + SW),
    .DEPTH(mcfir_pkg::FIFO_DEPTH),
    .AW(mcfir_pkg::FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(filter_ready),
    .in_ready(fifo_in_ready),
    .in_data({result_ch, res_q}),
    .out_valid(fifo_out_valid),
    .out_ready(out_ready && out_valid || !out_valid),
    .out_data(fifo_out)
  );

  // Registered output stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_valid <= 1'b0;
    end else if (out_ready || !out_valid) begin
      out_valid <= fifo_out_valid;
    end
  end

  // Result word and its channel tag, held while stalled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_data <= '0;
      out_channel <= '0;
    end else if (out_ready || !out_valid) begin
      out_data <= fifo_out[AW-1:0];
      out_channel <= fifo_out[AW+SW-1:AW];
    end
  end
endmodule // multichannel_fir_filter
`default_nettype wire

//--- core/stream_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count <= count + 1'b1;
      end else if (do_rd && !do_wr) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // stream_fifo
`default_nettype wire

//--- include/mcfir_pkg.sv
package mcfir_pkg;
  localparam int CHANNELS = 6;
  localparam int TAPS = 8;
  localparam int DATA_W = 8;
  localparam int COEF_W = 8;
  localparam int SEL_W = 3;
  localparam int ACC_W = 2 * DATA_W + 4;
  localparam int INTERLEAVE_DEPTH = CHANNELS + 1;
  localparam int TAP_DELAY = CHANNELS + 1;
  localparam int SLICE_PIPE = 3;
  localparam int LATENCY = (CHANNELS + 1) * TAPS + SLICE_PIPE;
  localparam int LAT_W = 7;
  localparam int LOAD_CYCLES = CHANNELS;
  localparam int FIFO_DEPTH = 32;
  localparam int FIFO_AW = 5;
  localparam real CLK_PERIOD_NS = 5.0;
  localparam logic [SEL_W-1:0] SEL_RESET = 3'h0;
  localparam logic [SEL_W-1:0] SEL_LAST = 3'h5;
  typedef enum logic [1:0] {ctl_idle, ctl_load, ctl_fill, ctl_run} ctl_state_e;
endpackage

//--- verif/mcfir_checker_sva.sv
`timescale 1ns/1ps
`default_nettype none
module mcfir_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic coef_load_start,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [mcfir_pkg::ACC_W-1:0] out_data,
  input wire logic [mcfir_pkg::SEL_W-1:0] out_channel,
  input wire logic coef_loading
);
  localparam int VALID_BY = mcfir_pkg::LATENCY + 20;
  int since_rst;
  // Cycles since reset release, saturating
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_rst <= 0;
    end else if (since_rst < 200) begin
      since_rst <= since_rst + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_load_six_clocks: assert property (
    $rose(coef_loading) |-> coef_loading [*6] ##1 !coef_loading)
    else $error("load strobe length off");
  a_load_follows_start: assert property (
    coef_load_start && !coef_loading |-> ##[1:3] coef_loading)
    else $error("load did not start");
  a_quiet_fill: assert property (
    since_rst < mcfir_pkg::LATENCY |-> !out_valid)
    else $error("valid before latency");
  a_valid_by_bound: assert property (
    since_rst == VALID_BY |-> out_valid)
    else $error("valid late");
  a_valid_holds: assert property (
    out_valid && !out_ready |=> out_valid)
    else $error("valid dropped in stall");
  a_data_holds: assert property (
    out_valid && !out_ready |=> $stable(out_data))
    else $error("data moved in stall");
  a_tag_holds: assert property (
    out_valid && !out_ready |=> $stable(out_channel))
    else $error("tag moved in stall");
  a_tag_range: assert property (
    out_valid |-> out_channel <= mcfir_pkg::SEL_LAST)
    else $error("tag out of range");
endmodule // mcfir_checker
bind multichannel_fir_filter mcfir_checker i_mcfir_checker (
  .clk(clk),
  .rst(rst),
  .coef_load_start(coef_load_start),
  .out_valid(out_valid),
  .out_ready(out_ready),
  .out_data(out_data),
  .out_channel(out_channel),
  .coef_loading(coef_loading)
);
`default_nettype wire

//--- verif/sample_sources.sv
`timescale 1ns/1ps
`default_nettype none
module sample_sources (
  // Clock
  input wire logic clk,
  // Level for all streams
  input wire logic [mcfir_pkg::DATA_W-1:0] level,
  // Six sample streams
  output var logic [mcfir_pkg::DATA_W-1:0] ch_sample [mcfir_pkg::CHANNELS]
);
  // Each stream presents a new sample every clock
  always @(posedge clk) begin
    for (int i = 0; i < mcfir_pkg::CHANNELS; i++) begin
      ch_sample[i] <= level;
    end
  end
  initial begin
    for (int i = 0; i < mcfir_pkg::CHANNELS; i++) begin
      ch_sample[i] = '0;
    end
  end
endmodule // sample_sources
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [mcfir_pkg::DATA_W-1:0] level = '0;
  logic per_channel_coefs = 1'b0;
  logic coef_load_start = 1'b0;
  logic [mcfir_pkg::COEF_W-1:0] coef_load_data [mcfir_pkg::TAPS];
  logic out_ready = 1'b1;
  logic [mcfir_pkg::DATA_W-1:0] ch_sample [mcfir_pkg::CHANNELS];
  logic out_valid;
  logic [mcfir_pkg::ACC_W-1:0] out_data;
  logic [mcfir_pkg::SEL_W-1:0] out_channel;
  logic overflow;
  logic coef_loading;
  int failures = 0;
  int checks_done = 0;
  always #2.5 clk = ~clk;
  sample_sources i_sample_sources (.clk(clk), .level(level), .ch_sample(ch_sample));
  multichannel_fir_filter i_multichannel_fir_filter (
    .clk(clk), .rst(rst), .ch_sample(ch_sample), .per_channel_coefs(per_channel_coefs),
    .coef_load_start(coef_load_start), .coef_load_data(coef_load_data),
    .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .out_channel(out_channel), .overflow(overflow), .coef_loading(coef_loading));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check_word(input string what, input logic [mcfir_pkg::ACC_W-1:0] exp,
                            input logic [mcfir_pkg::ACC_W-1:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_tag(input logic [mcfir_pkg::SEL_W-1:0] exp,
                           input logic [mcfir_pkg::SEL_W-1:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value out_channel expected %h seen %h", exp, got);
    end
  endtask
  task automatic check_flag(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Take one accepted word with out_ready held high
  task automatic take_word(output logic [mcfir_pkg::ACC_W-1:0] d,
                           output logic [mcfir_pkg::SEL_W-1:0] c);
    for (int i = 0; i < 200; i++) begin
      @(negedge clk);
      if (out_valid === 1'b1) begin
        d = out_data;
        c = out_channel;
        tick(1);
        return;
      end
    end
    failures++;
    $display("wrong value out_valid expected 1 seen 0");
    tally_and_finish();
  endtask
  // Load coefficients c0 + inc*t and count load strobe cycles
  task automatic load_coefs(input logic [7:0] c0, input logic [7:0] inc);
    int n;
    n = 0;
    for (int t = 0; t < mcfir_pkg::TAPS; t++) begin
      coef_load_data[t] = c0 + inc * 8'(t);
    end
    coef_load_start = 1'b1;
    tick(1);
    coef_load_start = 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      if (coef_loading === 1'b1) n++;
    end
    tick(1);
    check_word("load cycles", 20'h00006, mcfir_pkg::ACC_W'(n));
  endtask
  // Flush transients, then check sums and tag order
  task automatic steady_check();
    logic [mcfir_pkg::ACC_W-1:0] d;
    logic [mcfir_pkg::ACC_W-1:0] exp;
    logic [mcfir_pkg::SEL_W-1:0] c;
    logic [mcfir_pkg::SEL_W-1:0] prev;
    int s;
    s = 0;
    for (int k = 0; k < mcfir_pkg::TAPS; k++) s += int'($signed(coef_load_data[k]));
    exp = mcfir_pkg::ACC_W'(s * int'($signed(level)));
    tick(150);
    take_word(d, prev);
    for (int k = 0; k < 12; k++) begin
      take_word(d, c);
      check_word("out_data", exp, d);
      check_tag((prev == mcfir_pkg::SEL_LAST) ? mcfir_pkg::SEL_RESET : prev + 3'h1, c);
      prev = c;
    end
  endtask
  task automatic test_startup_shared();
    int n;
    n = 0;
    level = 8'h03;
    per_channel_coefs = 1'b0;
    load_coefs(8'h01, 8'h01);
    while (out_valid !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    check_flag("valid after latency", 1'b1, n >= mcfir_pkg::LATENCY - 8);
    steady_check();
    $display("test startup shared done");
  endtask
  task automatic test_reload_per_channel();
    level = 8'h05;
    per_channel_coefs = 1'b1;
    load_coefs(8'hFF, 8'h00);
    steady_check();
    $display("test reload per channel done");
  endtask
  task automatic test_stall_overflow();
    logic [mcfir_pkg::ACC_W-1:0] held;
    out_ready = 1'b0;
    tick(100);
    check_flag("overflow", 1'b1, overflow);
    check_flag("out_valid", 1'b1, out_valid);
    held = out_data;
    tick(5);
    check_word("held data", held, out_data);
    out_ready = 1'b1;
    tick(20);
    check_flag("overflow sticky", 1'b1, overflow);
    $display("test stall overflow done");
  endtask
  task automatic test_reset_restart();
    logic [mcfir_pkg::ACC_W-1:0] d;
    logic [mcfir_pkg::SEL_W-1:0] c;
    rst = 1'b1;
    tick(4);
    check_flag("overflow", 1'b0, overflow);
    check_flag("out_valid", 1'b0, out_valid);
    check_flag("coef_loading", 1'b0, coef_loading);
    rst = 1'b0;
    take_word(d, c);
    $display("test reset restart done");
  endtask
  initial begin
    for (int t = 0; t < mcfir_pkg::TAPS; t++) coef_load_data[t] = '0;
    tick(4);
    rst = 1'b0;
    test_startup_shared();
    test_reload_per_channel();
    test_stall_overflow();
    test_reset_restart();
    tally_and_finish();
  end
endmodule // tb_top
`default_nettype wire
